// >>> core/ldfs_defs.vh
// Timing and encoding constants for the LED driver fault sequencer
`ifndef LDFS_DEFS_VH
`define LDFS_DEFS_VH
// ------------------------------------------------------------
// Clock and times
// ------------------------------------------------------------
`define LDFS_CLK_HZ 40000000
`define LDFS_OTP_BLANK_US 250
`define LDFS_OTP_BLANK_CYC ((`LDFS_OTP_BLANK_US * (`LDFS_CLK_HZ / 1000000)) + 1)
`define LDFS_RECOVERY_MS 4000
`define LDFS_RECOVERY_CYC (`LDFS_RECOVERY_MS * (`LDFS_CLK_HZ / 1000))
`define LDFS_SHORT_MS 90
`define LDFS_SHORT_CYC (`LDFS_SHORT_MS * (`LDFS_CLK_HZ / 1000))
// ------------------------------------------------------------
// Counts and reference codes
// ------------------------------------------------------------
`define LDFS_OVERCUR_CYCLES 3'h4
`define LDFS_REF_HIGH_MV 8'hFA
`define LDFS_REF_LOW_MV 8'hC8
`define LDFS_FOLDBACK_PCT 7'h32
`define LDFS_CNT_W 28
`endif

// >>> core/ldfs_sequencer.v
// LED driver protection and start-up sequencer
`include "ldfs_defs.vh"
module ldfs_sequencer #(
   parameter [27:0] recovery_cyc = `LDFS_RECOVERY_CYC,
   parameter [27:0] short_cyc = `LDFS_SHORT_CYC
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire variant_auto_recovery,
   input wire variant_low_ref,
   input wire supply_above_start,
   input wire supply_below_stop,
   input wire supply_overvoltage,
   input wire sd_below_shutdown,
   input wire sd_overvoltage,
   input wire sd_below_foldback,
   input wire sd_above_second_temp,
   input wire cs_above_limit,
   input wire cs_above_150pct,
   input wire cs_pin_fault,
   input wire valley_above_short,
   input wire cycle_start,
   input wire dim_below_full_scale,
   input wire line_changed,
   input wire setpoint_changed,
   input wire valley_choice_valid,
   input wire [2:0] valley_choice,
   input wire ota_sinking,
   output reg gate_enable,
   output reg gate_off_now,
   output reg comp_ground,
   output reg comp_boost,
   output reg foldback_half,
   output reg [7:0] current_target_reference,
   output reg [2:0] locked_valley,
   output reg fault_latched,
   output reg fault_recovering,
   output reg otp_blanking
);
   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   localparam [4:0] st_off = 5'h01;
   localparam [4:0] st_blank = 5'h02;
   localparam [4:0] st_run = 5'h04;
   localparam [4:0] st_recover = 5'h08;
   localparam [4:0] st_latched = 5'h10;

   // Pin comparator results are asynchronous: two flops each
   localparam integer nsync = 16;
   wire [nsync-1:0] raw_in = {supply_above_start, supply_below_stop, supply_overvoltage,
      sd_below_shutdown, sd_overvoltage, sd_below_foldback, sd_above_second_temp,
      cs_above_limit, cs_above_150pct, cs_pin_fault, valley_above_short, cycle_start,
      dim_below_full_scale, line_changed, setpoint_changed, ota_sinking};
   reg [nsync-1:0] sync_a;
   reg [nsync-1:0] sync_b;
   genvar gi;
   generate
      for (gi = 0; gi < nsync; gi = gi + 1) begin : g_sync
         // Second flop is the only reader of the first
         always @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               sync_a[gi] <= 1'b0;
               sync_b[gi] <= 1'b0;
            end else begin
               sync_a[gi] <= raw_in[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate
   wire s_start = sync_b[15];
   wire s_stop = sync_b[14];
   wire s_vcc_ov = sync_b[13];
   wire s_sd_low = sync_b[12];
   wire s_sd_ov = sync_b[11];
   wire s_fold = sync_b[10];
   wire s_temp2 = sync_b[9];
   wire s_ilim = sync_b[8];
   wire s_i150 = sync_b[7];
   wire s_cs_bad = sync_b[6];
   wire s_valley_hi = sync_b[5];
   wire s_cycle = sync_b[4];
   wire s_dim_low = sync_b[3];
   wire s_line_chg = sync_b[2];
   wire s_set_chg = sync_b[1];
   wire s_ota_sink = sync_b[0];

   reg [4:0] state;
   reg [4:0] next_state;
   reg [27:0] timer;
   reg [27:0] short_timer;
   reg [2:0] overcur_count;
   reg boost_done;
   reg reset_hold;
   // Last timer value of the blanking interval, cut to the timer width on purpose
   localparam [27:0] blank_last = `LDFS_OTP_BLANK_CYC - 1;

   // ------------------------------------------------------------
   // Fault decode
   // ------------------------------------------------------------
   // Over-temperature sources are ignored while blanking
   wire otp_fault = (state == st_run) && (s_sd_low || s_temp2);
   wire sd_ov_fault = (state == st_run) && s_sd_ov;
   wire overcur_fault = (state == st_run) && s_cycle && s_i150
      && (overcur_count == `LDFS_OVERCUR_CYCLES - 3'h1);
   wire short_fault = (state == st_run) && (short_timer >= short_cyc - 28'h1)
      && !s_valley_hi;
   wire vcc_ov_fault = (state != st_off) && (state != st_latched) && s_vcc_ov;
   // Variant-selected faults: latch or recover
   wire major_fault = otp_fault || sd_ov_fault || overcur_fault || short_fault;
   wire any_fault = major_fault || vcc_ov_fault;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always @* begin
      next_state = state;
      case (state)
         st_off: begin
            if (s_start) begin
               next_state = st_blank;
            end
         end
         st_blank, st_run: begin
            if (s_stop) begin
               next_state = st_off;
            end else if (any_fault) begin
               // Open-LED overvoltage recovers unless a stop or a latching major fault in the same cycle wins
               if (major_fault && !variant_auto_recovery) begin
                  next_state = st_latched;
               end else begin
                  next_state = st_recover;
               end
            end else if (state == st_blank && timer >= blank_last) begin
               next_state = st_run;
            end
         end
         st_recover: begin
            if (timer >= recovery_cyc - 28'h1) begin
               next_state = st_off;
            end
         end
         st_latched: begin
            if (s_stop) begin
               next_state = st_off;
            end
         end
         default: next_state = st_off;
      endcase
   end

   // State register and shared delay timer
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= st_off;
         timer <= 28'h0;
      end else begin
         state <= next_state;
         if (next_state != state) begin
            timer <= 28'h0;
         end else if (timer != 28'hFFFFFFF) begin
            timer <= timer + 28'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // Fault counters
   // ------------------------------------------------------------
   // Short timer is kept across undervoltage hiccups; recovery, latch or a valley above the short level clears it
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         short_timer <= 28'h0;
         overcur_count <= 3'h0;
      end else begin
         if (state == st_recover || state == st_latched) begin
            short_timer <= 28'h0;
            overcur_count <= 3'h0;
         end else begin
            if (s_valley_hi) begin
               short_timer <= 28'h0;
            end else if ((state == st_blank || state == st_run) && short_timer < short_cyc) begin
               short_timer <= short_timer + 28'h1;
            end
            // A cycle below 150 percent breaks the consecutive run
            if (state == st_run && s_cycle) begin
               overcur_count <= s_i150 ? overcur_count + 3'h1 : 3'h0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Loop-filter node control
   // ------------------------------------------------------------
   // Boost runs once per start sequence; undervoltage restart keeps node level
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         boost_done <= 1'b0;
         comp_ground <= 1'b1;
         comp_boost <= 1'b0;
      end else begin
         if (next_state == st_recover || next_state == st_latched) begin
            boost_done <= 1'b0;
         end else if ((state == st_blank || state == st_run) && s_ota_sink) begin
            boost_done <= 1'b1;
         end
         // Ground on fault paths and in off after power-up or recovery, never for a plain undervoltage stop
         comp_ground <= (next_state == st_recover) || (next_state == st_latched)
            || (reset_hold && next_state == st_off);
         comp_boost <= (next_state == st_blank || next_state == st_run)
            && !boost_done && !s_ota_sink;
      end
   end

   // Off from power-up is grounded; off after undervoltage keeps the level
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reset_hold <= 1'b1;
      end else if (state == st_blank) begin
         reset_hold <= 1'b0;
      end else if (state == st_recover) begin
         reset_hold <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Gate drive, reference and valley lock
   // ------------------------------------------------------------
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gate_enable <= 1'b0;
         gate_off_now <= 1'b0;
         foldback_half <= 1'b0;
         current_target_reference <= 8'h00;
         locked_valley <= 3'h0;
         fault_latched <= 1'b0;
         fault_recovering <= 1'b0;
         otp_blanking <= 1'b0;
      end else begin
         gate_enable <= (next_state == st_blank || next_state == st_run)
            && !s_sd_low && !s_cs_bad;
         gate_off_now <= s_ilim;
         foldback_half <= s_fold;
         // Dimming and foldback scale the reference outside this block
         current_target_reference <= variant_low_ref ? `LDFS_REF_LOW_MV
            : `LDFS_REF_HIGH_MV;
         if (valley_choice_valid && (locked_valley == 3'h0 || s_line_chg || s_set_chg)) begin
            locked_valley <= valley_choice;
         end
         fault_latched <= (next_state == st_latched);
         fault_recovering <= (next_state == st_recover);
         otp_blanking <= (next_state == st_blank);
      end
   end
   wire unused_dim = s_dim_low;
endmodule

// >>> tb/ldfs_seq_assertions.sv
// Port-level checker for the LED driver fault sequencer
`include "ldfs_defs.vh"
module ldfs_seq_assertions #(
   parameter [27:0] recovery_cyc = 28'h00000C8
) (
   input logic sys_clk,
   input logic sys_rst,
   input logic variant_low_ref,
   input logic supply_below_stop,
   input logic sd_below_shutdown,
   input logic cs_above_limit,
   input logic cs_above_150pct,
   input logic cycle_start,
   input logic ota_sinking,
   input logic gate_enable,
   input logic gate_off_now,
   input logic comp_ground,
   input logic comp_boost,
   input logic [7:0] current_target_reference,
   input logic fault_latched,
   input logic fault_recovering,
   input logic otp_blanking
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int BLANK_MIN = 10001;
   int blank_cnt;
   int rec_cnt;
   logic [2:0] oc_run;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // ----------------------------------------
   // Helper counters
   // ----------------------------------------
   // Lengths of blanking and recovery, and the run of over-150% cycles
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         blank_cnt <= 0;
         rec_cnt <= 0;
         oc_run <= 3'h0;
      end else begin
         blank_cnt <= otp_blanking ? blank_cnt + 1 : 0;
         rec_cnt <= fault_recovering ? rec_cnt + 1 : 0;
         if (cycle_start)
            oc_run <= !cs_above_150pct ? 3'h0 : (oc_run == 3'h4) ? oc_run : oc_run + 3'h1;
      end
   end
   sequence s_trip;
      ##[1:6] (!gate_enable && (fault_latched || fault_recovering));
   endsequence
   property p_cut; cs_above_limit[*4] |-> gate_off_now; endproperty
   a_cut: assert property (p_cut) else $error("switch not cut");
   property p_stop; (sd_below_shutdown && !otp_blanking)[*4] |-> !gate_enable; endproperty
   a_stop: assert property (p_stop) else $error("shutdown ignored");
   property p_blank;
      $fell(otp_blanking) && gate_enable |-> blank_cnt >= BLANK_MIN && blank_cnt <= BLANK_MIN + 1;
   endproperty
   a_blank: assert property (p_blank) else $error("blanking length wrong");
   property p_oc; $rose(oc_run == 3'h4) |-> s_trip; endproperty
   a_oc: assert property (p_oc) else $error("overcurrent run not tripped");
   property p_gnd; fault_latched || fault_recovering |-> comp_ground && !gate_enable; endproperty
   a_gnd: assert property (p_gnd) else $error("fault without grounded node");
   property p_latch; $fell(fault_latched) |-> $past(supply_below_stop, 2); endproperty
   a_latch: assert property (p_latch) else $error("latch cleared early");
   property p_rec;
      $fell(fault_recovering) |-> rec_cnt >= recovery_cyc && rec_cnt <= recovery_cyc + 1;
   endproperty
   a_rec: assert property (p_rec) else $error("recovery delay wrong");
   property p_boost; ota_sinking[*4] |-> !comp_boost; endproperty
   a_boost: assert property (p_boost) else $error("boost still on");
   property p_ref;
      gate_enable |-> current_target_reference
         == (variant_low_ref ? `LDFS_REF_LOW_MV : `LDFS_REF_HIGH_MV);
   endproperty
   a_ref: assert property (p_ref) else $error("reference wrong");
endmodule
bind ldfs_sequencer ldfs_seq_assertions #(.recovery_cyc(recovery_cyc)) u_chk (.*);

// >>> tb/ldfs_power_stage.sv
// Behavioural power stage: switching cycles and valley ringing
module ldfs_power_stage (
   input logic sys_clk,
   input logic gate_enable,
   input logic short_load,
   output logic cycle_start = 1'b0,
   output logic valley_above_short = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] phase = 2'h0;
   // One-cycle end pulse every fourth clock; a shorted load keeps the pin low
   always @(posedge sys_clk) begin
      phase <= #2 gate_enable ? phase + 2'h1 : 2'h0;
      cycle_start <= #2 gate_enable && (phase == 2'h3);
      valley_above_short <= #2 gate_enable && !short_load && (phase == 2'h0);
   end
endmodule

// >>> tb/ldfs_sequencer_tb.sv
// Self-checking bench for the LED driver fault sequencer
module ldfs_sequencer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 1'b0, sys_rst = 1'b1, variant_auto_recovery = 1'b1, variant_low_ref = 1'b0;
   logic supply_above_start = 1'b0, supply_below_stop = 1'b0, supply_overvoltage = 1'b0;
   logic sd_below_shutdown = 1'b0, sd_overvoltage = 1'b0, sd_below_foldback = 1'b0;
   logic sd_above_second_temp = 1'b0, cs_above_limit = 1'b0, cs_above_150pct = 1'b0;
   logic cs_pin_fault = 1'b0, dim_below_full_scale = 1'b0, line_changed = 1'b0;
   logic setpoint_changed = 1'b0, valley_choice_valid = 1'b0, ota_sinking = 1'b0;
   logic short_load = 1'b0;
   logic [2:0] valley_choice = 3'h0;
   logic cycle_start, valley_above_short, gate_enable, gate_off_now, comp_ground, comp_boost;
   logic foldback_half, fault_latched, fault_recovering, otp_blanking;
   logic [7:0] current_target_reference;
   logic [2:0] locked_valley;
   int err_total = 0;
   int checks_done = 0;
   // Short counts keep each recovery and short trip brief
   ldfs_sequencer #(.recovery_cyc(28'h00000C8), .short_cyc(28'h0000064)) DUT (.*);
   ldfs_power_stage u_stage (.*);
   always #12.5 sys_clk = ~sys_clk;
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("Mismatches %0d, checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Bounded wait for the switching permission to reach a level
   task automatic wait_gate(input logic v);
      for (int n = 0; gate_enable !== v; n++) begin
         if (n == 2000) begin
            err_total++;
            finish_test();
         end
         tick(1);
      end
   endtask
   // Wait for switching to resume and for blanking to run out
   task automatic restart();
      wait_gate(1'b1);
      tick(10010);
      check("blank", otp_blanking, 8'h00);
   endtask
   task automatic trip(input int k);
      case (k)
         0: supply_overvoltage = 1'b1;
         1: sd_overvoltage = 1'b1;
         2: sd_above_second_temp = 1'b1;
         default: cs_pin_fault = 1'b1;
      endcase
      wait_gate(1'b0);
      {supply_overvoltage, sd_overvoltage, sd_above_second_temp, cs_pin_fault} = 4'h0;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      tick(3);
      check("ground", comp_ground, 8'h01);
      sys_rst = 1'b0;
      supply_above_start = 1'b1;
      tick(4);
      check("blank", otp_blanking, 8'h01);
      check("boost", comp_boost, 8'h01);
      check("ground", comp_ground, 8'h00);
      ota_sinking = 1'b1;
      tick(4);
      check("boost", comp_boost, 8'h00);
      ota_sinking = 1'b0;
      tick(9990);
      check("blank", otp_blanking, 8'h01);
      tick(20);
      check("blank", otp_blanking, 8'h00);
      cs_above_limit = 1'b1;
      tick(4);
      check("cut", gate_off_now, 8'h01);
      cs_above_limit = 1'b0;
      tick(4);
      check("cut", gate_off_now, 8'h00);
      check("ref", current_target_reference, 8'hFA);
      sd_below_foldback = 1'b1;
      tick(4);
      check("half", foldback_half, 8'h01);
      check("gate", gate_enable, 8'h01);
      sd_below_foldback = 1'b0;
      valley_choice_valid = 1'b1;
      valley_choice = 3'h3;
      tick(4);
      valley_choice = 3'h5;
      tick(4);
      check("valley", locked_valley, 8'h03);
      line_changed = 1'b1;
      tick(4);
      check("valley", locked_valley, 8'h05);
      line_changed = 1'b0;
      // Three over-limit cycles pass, the fourth trips
      cs_above_150pct = 1'b1;
      tick(10);
      check("gate", gate_enable, 8'h01);
      wait_gate(1'b0);
      check("recover", fault_recovering, 8'h01);
      check("ground", comp_ground, 8'h01);
      cs_above_150pct = 1'b0;
      restart();
      check("ground", comp_ground, 8'h00);
      short_load = 1'b1;
      tick(90);
      check("gate", gate_enable, 8'h01);
      wait_gate(1'b0);
      check("recover", fault_recovering, 8'h01);
      short_load = 1'b0;
      restart();
      for (int k = 0; k < 4; k++) begin
         trip(k);
         check("recover", fault_recovering, (k == 3) ? 8'h00 : 8'h01);
         restart();
      end
      // Undervoltage stop keeps the loop-filter level
      supply_above_start = 1'b0;
      supply_below_stop = 1'b1;
      wait_gate(1'b0);
      tick(4);
      check("ground", comp_ground, 8'h00);
      supply_below_stop = 1'b0;
      supply_above_start = 1'b1;
      restart();
      sys_rst = 1'b1;
      variant_auto_recovery = 1'b0;
      variant_low_ref = 1'b1;
      tick(3);
      sys_rst = 1'b0;
      restart();
      check("ref", current_target_reference, 8'hC8);
      sd_below_shutdown = 1'b1;
      wait_gate(1'b0);
      check("latch", fault_latched, 8'h01);
      sd_below_shutdown = 1'b0;
      tick(300);
      check("latch", fault_latched, 8'h01);
      supply_above_start = 1'b0;
      supply_below_stop = 1'b1;
      tick(5);
      check("latch", fault_latched, 8'h00);
      finish_test();
   end
endmodule
